// ==== irq_gen_map.vh ====
// Constants for the endpoint interrupt request generator.
// Assumes inclusion by irq_gen.v only; irq_msg_fmt.v does not include it.
`ifndef IRQ_GEN_MAP_VH
`define IRQ_GEN_MAP_VH
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_MSI_ADDR_LO 12'h004
`define OFS_MSI_ADDR_HI 12'h008
`define OFS_MSI_DATA 12'h00C
`define OFS_STATUS 12'h010
`define OFS_CAP 12'h014
// Control field positions
`define CTRL_MSI_EN 0
`define CTRL_MSIX_EN 1
`define CTRL_INTX_DIS 10
`define CTRL_MMEN_LSB 4
`define CTRL_MMEN_MSB 6
`define CTRL_RESET 32'h00000000
// Capability field
`define CAP_MMCAP_DEFAULT 3'h5
// Message kinds on the transmit port
`define KIND_ASSERT_INTA 2'h1
`define KIND_DEASSERT_INTA 2'h2
`define KIND_MSI_WR32 2'h3
`define KIND_MSI_WR64 2'h0
`endif

// ==== irq_msg_fmt.v ====
// MSI payload builder: merges user vector bits into the message data.
// Assumes the mask width comes from the lesser of capable and enabled counts.
`default_nettype none
module irq_msg_fmt (
	input wire [15:0] msg_data,
	input wire [2:0] vec_bits,
	input wire [4:0] vec_index,
	output wire [15:0] payload
);
	reg [15:0] mask;
	integer i;
	always @* begin
		mask = 16'h0000;
		for (i = 0; i < 5; i = i + 1) begin
			if (i < vec_bits)
				mask[i] = 1'b1;
		end
	end
	// Bits the host did not grant keep the programmed data
	assign payload = (msg_data & ~mask) | ({11'h000, vec_index} & mask);
endmodule // irq_msg_fmt
`default_nettype wire

// ==== irq_gen.v ====
// Endpoint interrupt request generator with AHB-Lite configuration port.
// Assumes one AHB-Lite master; transmit port accepts a message when tx_ready is high.
`include "irq_gen_map.vh"
`default_nettype none
// What this block and its user do
// RL1: Both flags low: only INTx messages sent
// RL2: MSI flag only: send MSI memory writes
// RL3: MSI-X flag only: MSI-X mode, no internal messages
// RL4: Both flags high: still send MSI writes
// RL5: Mode flag outputs follow enable bits
// RL6: Enable bits written only by host
// RL7: Internal logic makes legacy and MSI only
// RL8: Command bit 10 set blocks INTx
// RL9: Legacy request accepted with done pulse
// RL10: Request drop sends deassert, second done
// RL11: User holds request until serviced
// RL12: User holds pending with request
// RL13: Nonzero MSI vector gives done, one write
// RL14: Address and data from capability fields
// RL15: 64-bit address only if upper nonzero
// RL16: Vector bits limited by lesser count
// RL17: Mask vector bits host did not enable
// RL18: User encodes MSI request one-hot
// RL19: User skips masked vectors itself
// RL20: User builds MSI-X table and array
// RL21: INTx enable state shown on flags
// RL22: Each done pulse lasts one cycle
module irq_gen (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire legacy_req,
	input wire legacy_pending,
	output reg legacy_done,
	input wire [31:0] msi_req,
	output reg msi_done,
	output wire msi_mode,
	output wire msix_mode,
	output wire [2:0] msi_mm_enable,
	output wire [3:0] function_flags,
	output reg tx_valid,
	input wire tx_ready,
	output reg [1:0] tx_kind,
	output reg [63:0] tx_addr,
	output reg [31:0] tx_data,
	output reg intx_status
);
	localparam S_IDLE = 5'b00001;
	localparam S_ASSERT = 5'b00010;
	localparam S_HELD = 5'b00100;
	localparam S_DEASSERT = 5'b01000;
	localparam S_MSI = 5'b10000;

	reg [31:0] ctrl_reg;
	reg [31:0] addr_lo_reg;
	reg [31:0] addr_hi_reg;
	reg [15:0] msg_data_reg;
	reg [2:0] mmcap_reg;
	reg [4:0] state_reg;
	reg [4:0] state_next;
	reg intx_sent_reg;
	reg wr_pend_reg;
	reg [11:0] wr_addr_reg;
	reg [31:0] msi_hold_reg;
	wire msi_en;
	wire msix_en;
	wire intx_dis;
	wire [2:0] mmen;
	wire [2:0] vec_bits;
	wire [4:0] vec_index;
	wire [15:0] payload;
	wire msi_active;
	wire ahb_go;

	// Lowest set bit of a one-hot vector request
	function [4:0] first_one;
		input [31:0] v;
		integer k;
		begin
			first_one = 5'h00;
			for (k = 31; k >= 0; k = k - 1) begin
				if (v[k])
					first_one = k[4:0];
			end
		end
	endfunction

	assign msi_en = ctrl_reg[`CTRL_MSI_EN];
	assign msix_en = ctrl_reg[`CTRL_MSIX_EN];
	assign intx_dis = ctrl_reg[`CTRL_INTX_DIS];
	assign mmen = ctrl_reg[`CTRL_MMEN_MSB:`CTRL_MMEN_LSB];
	assign msi_mode = msi_en; // RL5
	assign msix_mode = msix_en; // RL5
	assign msi_mm_enable = mmen;
	// Flags: INTx disabled, legacy mode, MSI mode, MSI-X mode
	assign function_flags = {msix_en, msi_en, ~msi_en & ~msix_en, intx_dis}; // RL21
	// MSI writes whenever MSI is enabled, even with MSI-X also set
	assign msi_active = msi_en; // RL2 RL4
	assign vec_bits = (mmen < mmcap_reg) ? mmen : mmcap_reg; // RL16
	assign vec_index = first_one(msi_hold_reg);

	irq_msg_fmt u_fmt (
		.msg_data(msg_data_reg),
		.vec_bits(vec_bits),
		.vec_index(vec_index),
		.payload(payload)
	); // RL17

	// Bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ahb_go = hsel & hready & htrans[1];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
		end else begin
			wr_pend_reg <= ahb_go & hwrite;
			wr_addr_reg <= haddr;
		end
	end

	// Only the host's configuration path writes the enable bits; no user port reaches them
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= `CTRL_RESET;
			addr_lo_reg <= 32'h00000000;
			addr_hi_reg <= 32'h00000000;
			msg_data_reg <= 16'h0000;
			mmcap_reg <= `CAP_MMCAP_DEFAULT;
		end else if (wr_pend_reg) begin
			case (wr_addr_reg)
				`OFS_CTRL: ctrl_reg <= hwdata & 32'h00000473; // RL6
				`OFS_MSI_ADDR_LO: addr_lo_reg <= {hwdata[31:2], 2'b00};
				`OFS_MSI_ADDR_HI: addr_hi_reg <= hwdata;
				`OFS_MSI_DATA: msg_data_reg <= hwdata[15:0];
				`OFS_CAP: mmcap_reg <= hwdata[2:0];
				default: ;
			endcase
		end
	end

	// Read data registered in the address phase, so it stands in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (ahb_go & ~hwrite) begin
			case (haddr)
				`OFS_CTRL: hrdata <= ctrl_reg;
				`OFS_MSI_ADDR_LO: hrdata <= addr_lo_reg;
				`OFS_MSI_ADDR_HI: hrdata <= addr_hi_reg;
				`OFS_MSI_DATA: hrdata <= {16'h0000, msg_data_reg};
				`OFS_STATUS: hrdata <= {26'h0000000, intx_status, intx_sent_reg, state_reg[3:0]};
				`OFS_CAP: hrdata <= {29'h00000000, mmcap_reg};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				// MSI-X mode alone: internal logic stays quiet, user sends on stream
				if (msi_active && msi_req != 32'h00000000)
					state_next = S_MSI; // RL13 RL3 RL7
				else if (!msi_en && !msix_en && legacy_req && legacy_pending)
					state_next = S_ASSERT; // RL1
			end
			S_ASSERT: begin
				if (intx_dis || tx_ready)
					state_next = S_HELD; // RL8 RL9
			end
			S_HELD: begin
				if (!legacy_req)
					state_next = intx_sent_reg ? S_DEASSERT : S_IDLE; // RL10
			end
			S_DEASSERT: begin
				if (tx_ready)
					state_next = S_IDLE; // RL10
			end
			S_MSI: begin
				// Leave only once the write has really been taken, not on a stray ready
				if (tx_valid && tx_ready)
					state_next = S_IDLE; // RL13
			end
			default: state_next = S_IDLE;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= S_IDLE;
			intx_sent_reg <= 1'b0;
			msi_hold_reg <= 32'h00000000;
			legacy_done <= 1'b0;
			msi_done <= 1'b0;
			tx_valid <= 1'b0;
			tx_kind <= `KIND_ASSERT_INTA;
			tx_addr <= 64'h0000000000000000;
			tx_data <= 32'h00000000;
			intx_status <= 1'b0;
		end else begin
			state_reg <= state_next;
			legacy_done <= 1'b0; // RL22
			msi_done <= 1'b0; // RL22
			if (tx_valid && tx_ready)
				tx_valid <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (state_next == S_MSI) begin
						msi_hold_reg <= msi_req;
						msi_done <= 1'b1; // RL13
					end else if (state_next == S_ASSERT) begin
						legacy_done <= 1'b1; // RL9
						intx_status <= 1'b1;
						intx_sent_reg <= ~intx_dis; // RL8
						if (!intx_dis) begin
							tx_valid <= 1'b1;
							tx_kind <= `KIND_ASSERT_INTA; // RL9
						end
					end
				end
				S_MSI: begin
					if (!tx_valid) begin
						tx_valid <= 1'b1;
						tx_data <= {16'h0000, payload}; // RL14
						if (addr_hi_reg != 32'h00000000) begin
							tx_kind <= `KIND_MSI_WR64; // RL15
							tx_addr <= {addr_hi_reg, addr_lo_reg}; // RL14
						end else begin
							tx_kind <= `KIND_MSI_WR32; // RL15
							tx_addr <= {32'h00000000, addr_lo_reg};
						end
					end
				end
				S_HELD: begin
					intx_status <= legacy_pending;
					if (!legacy_req) begin
						intx_status <= 1'b0;
						if (intx_sent_reg) begin
							tx_valid <= 1'b1;
							tx_kind <= `KIND_DEASSERT_INTA; // RL10
						end else
							legacy_done <= 1'b1;
					end
				end
				S_DEASSERT: begin
					if (tx_ready) begin
						legacy_done <= 1'b1; // RL10
						intx_sent_reg <= 1'b0;
					end
				end
				default: ;
			endcase
		end
	end
endmodule // irq_gen
`default_nettype wire

// ==== irq_gen_chk.sv ====
// Port checker for irq_gen.
// Assumes one clock domain with hresetn async active low.
`default_nettype none
module irq_gen_chk(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic legacy_done,
	input wire logic msi_done,
	input wire logic msi_mode,
	input wire logic msix_mode,
	input wire logic [3:0] function_flags,
	input wire logic tx_valid,
	input wire logic [1:0] tx_kind,
	input wire logic [63:0] tx_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Kinds 1 and 2 are the INTx messages
	wire logic intx = tx_valid && tx_kind[1] != tx_kind[0];
	property p_ld; legacy_done |=> !legacy_done; endproperty
	a_ld: assert property (p_ld) else $error("legacy done too long");
	property p_md; msi_done |=> !msi_done; endproperty
	a_md: assert property (p_md) else $error("msi done too long");
	property p_fl; function_flags[3:1] == {msix_mode, msi_mode, !(msi_mode || msix_mode)}; endproperty
	a_fl: assert property (p_fl) else $error("flags");
	property p_lg; intx |-> !msi_mode && !msix_mode; endproperty
	a_lg: assert property (p_lg) else $error("intx outside legacy");
	property p_ms; tx_valid && !intx |-> msi_mode; endproperty
	a_ms: assert property (p_ms) else $error("msi outside msi");
	property p_ds; intx && tx_kind == 2'h1 |-> !function_flags[0]; endproperty
	a_ds: assert property (p_ds) else $error("intx while disabled");
	property p_wr; msi_done |=> tx_valid && !intx; endproperty
	a_wr: assert property (p_wr) else $error("no msi write");
	property p_ad; tx_valid && !intx |-> (tx_kind == 2'h0) == (|tx_addr[63:32]); endproperty
	a_ad: assert property (p_ad) else $error("address size");
	cover property (legacy_done ##[1:40] legacy_done);
	cover property (msi_done);
	cover property (tx_valid && tx_kind == 2'h0);
endmodule // irq_gen_chk
bind irq_gen irq_gen_chk u_chk(.hclk, .hresetn, .legacy_done, .msi_done, .msi_mode, .msix_mode,
	.function_flags, .tx_valid, .tx_kind, .tx_addr);
`default_nettype wire

// ==== irq_user_model.sv ====
// User-side requester for irq_gen: legacy and MSI requests.
// Assumes its tasks are called just after a rising edge.
`default_nettype none
module irq_user_model(
	input wire logic hclk,
	input wire logic legacy_done,
	input wire logic msi_done,
	output logic legacy_req,
	output logic legacy_pending,
	output logic [31:0] msi_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {legacy_req, legacy_pending, msi_req} = 34'h0;
	// Five cycles past the accept stand in for the host service routine
	task automatic legacy(output int n);
		int s;
		n = 0;
		s = 0;
		{legacy_req, legacy_pending} <= 2'h3;
		repeat (40) begin
			@(posedge hclk);
			if (legacy_done === 1'h1) n++;
			if (n > 0) s++;
			if (s == 5) {legacy_req, legacy_pending} <= 2'h0;
		end
	endtask
	task automatic msi(input logic [4:0] idx, output int n);
		n = 0;
		// No per-vector mask and no MSI-X table here, so every vector may be raised
		msi_req <= 32'h1 << idx;
		repeat (20) begin
			@(posedge hclk);
			if (msi_done === 1'h1) begin
				n++;
				msi_req <= 32'h0;
			end
		end
		if (n == 0) msi_req <= 32'h0;
	endtask
endmodule // irq_user_model
`default_nettype wire

// ==== tb_endpoint_interrupt_request_gen.sv ====
// Bench for irq_gen: register, legacy and MSI traffic against a bench model.
// Assumes irq_gen, irq_gen_chk and irq_user_model are compiled first.
`default_nettype none
module tb_endpoint_interrupt_request_gen;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, tx_ready = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [11:0] haddr = 12'h0;
	logic [31:0] hwdata = 32'h0, rd, lo, hi, dat, c;
	logic [15:0] mk;
	logic [4:0] idx;
	logic [97:0] q[$];
	int err_count = 0, check_count = 0, n, m, k;
	wire logic hready, legacy_done, msi_done, msi_mode, msix_mode, tx_valid, legacy_req, legacy_pending, intx_st;
	wire logic [1:0] tx_kind;
	wire logic [2:0] mmen;
	wire logic [3:0] flags;
	wire logic [31:0] hrdata, tx_data, msi_req;
	wire logic [63:0] tx_addr;
	irq_gen u_irq_gen(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready, .hwdata, .hrdata,
		.hreadyout(hready), .hresp(), .legacy_req, .legacy_pending, .legacy_done, .msi_req, .msi_done, .msi_mode,
		.msix_mode, .msi_mm_enable(mmen), .function_flags(flags), .tx_valid, .tx_ready, .tx_kind, .tx_addr,
		.tx_data, .intx_status(intx_st));
	irq_user_model u_irq_user_model(.hclk, .legacy_done, .msi_done, .legacy_req, .legacy_pending, .msi_req);
	task automatic chk(input logic [97:0] s, input logic [97:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'h1);
		rd = hrdata;
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial forever #20 hclk = ~hclk;
	// About 325 cycles of tests; the limit allows about 23 times that
	initial begin
		#300000;
		err_count++;
		end_of_test;
	end
	// Random ready stalls the message port; accepted messages are logged
	always @(posedge hclk) begin
		tx_ready <= 1'($urandom);
		if (tx_valid && tx_ready) q.push_back({tx_kind, tx_addr, tx_data});
	end
	initial begin
		void'($urandom(32'h61CBE36D));
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		bus(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		bus(1'h0, 12'h014, 32'h0);
		chk(rd, 32'h5);
		bus(1'h1, 12'h000, 32'hFFFFFFFF);
		bus(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h473);
		chk({mmen, flags}, 7'h7D);
		bus(1'h0, 12'h020, 32'h0);
		chk(rd, 32'h0);
		$display("register test done");
		for (m = 0; m < 2; m++) begin
			bus(1'h1, 12'h000, m ? 32'h400 : 32'h0);
			q.delete();
			u_irq_user_model.legacy(n);
			chk(n, 2);
			chk(q.size(), m ? 0 : 2);
			if (m == 0) chk({q[0][97:96], q[1][97:96]}, 4'h6);
			chk(flags, 4'h2 + m);
			chk(intx_st, 1'h0);
		end
		$display("legacy test done");
		for (m = 0; m < 8; m++) begin
			k = m % 6;
			lo = $urandom & 32'hFFFFFFFC;
			hi = m[0] ? $urandom | 32'h1 : 32'h0;
			dat = $urandom;
			idx = 5'($urandom);
			c = (m == 6 ? 32'h2 : m == 5 ? 32'h3 : 32'h1) | k << 4;
			mk = (16'h1 << k) - 16'h1;
			bus(1'h1, 12'h004, lo);
			bus(1'h1, 12'h008, hi);
			bus(1'h1, 12'h00C, dat);
			bus(1'h1, 12'h000, c);
			q.delete();
			u_irq_user_model.msi(idx, n);
			chk(n + q.size(), m == 6 ? 0 : 2);
			if (m != 6) begin
				chk(q[0][97:32], {hi != 32'h0 ? 2'h0 : 2'h3, hi, lo});
				chk(q[0][31:0], {16'h0, dat[15:0] & ~mk | {11'h0, idx} & mk});
			end
		end
		$display("msi test done");
		end_of_test;
	end
endmodule // tb_endpoint_interrupt_request_gen
`default_nettype wire
